// ==== core/acr_pkg.sv ====
/*
 * acr_pkg: register map, field positions, reset values and
 * constants of the converter control and result block.
 * assumes: included by name only, nothing imported.
 */
package acr_pkg;
	// ----------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------
	localparam logic [2:0] IDX_SETUP   = 3'h1;
	localparam logic [2:0] IDX_PINS    = 3'h2;
	localparam logic [2:0] IDX_GAINCAL = 3'h3;
	localparam logic [2:0] IDX_RESULT  = 3'h4;
	localparam int         ADR_W       = 5;
	// ----------------------------------------------------------
	// converter_setup fields
	// ----------------------------------------------------------
	localparam int F_MAINS   = 7;
	localparam int F_UNIPOL  = 6;
	localparam int F_CLKSRC  = 5;
	localparam int F_REFERENCE_BUFFER_ENABLE  = 4;
	localparam int F_INBUF   = 3;
	localparam int F_CODING  = 2;
	localparam int F_SINGLE  = 1;
	localparam logic [7:0] SETUP_MASK = 8'hfe;
	localparam logic [7:0] SETUP_RST  = 8'h02;
	// ----------------------------------------------------------
	// pin_direction_value and gain_calibration_control
	// ----------------------------------------------------------
	localparam int F_DIR_LO  = 4;
	localparam logic [7:0] PINS_RST   = 8'h0f;
	localparam int F_GAIN_LO = 5;
	localparam int F_SYSG    = 4;
	localparam int F_SYSO    = 3;
	localparam int F_SELFG   = 2;
	localparam int F_SELFO   = 1;
	localparam logic [7:0] GCAL_MASK  = 8'hfe;
	localparam logic [7:0] GCAL_RST   = 8'h1e;
	localparam logic [2:0] GAIN_MAX   = 3'h4;
	// ----------------------------------------------------------
	// conversion and arithmetic
	// ----------------------------------------------------------
	localparam logic [1:0] SKIP_CNT   = 2'h3;
	localparam logic [4:0] RES_BITS   = 5'h18;
	localparam int         COEF_SHIFT = 22;
	localparam logic signed [51:0] UNI_MAX = 52'h0000000ffffff;
	localparam logic signed [51:0] BIP_MAX = 52'h00000007fffff;
	localparam logic signed [51:0] BIP_MIN = 52'hfffffff800000;
	typedef enum logic [1:0] {ST_SLEEP, ST_CONV} acr_state_t;
endpackage : acr_pkg

// ==== core/acr_sync.sv ====
/*
 * acr_sync: two-stage synchroniser for pin-level inputs.
 * assumes: inputs are asynchronous levels; ce_i freezes it.
 */
`timescale 1ns/1ps
module acr_sync #(
	parameter int W = 6
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : acr_sync

// ==== core/acr_result_calc.sv ====
/*
 * acr_result_calc: corrections, digital gain, clipping and
 * output coding of one raw conversion sample.
 * assumes: raw sample is signed full scale; gain coefficients
 * use 0x400000 as unity, so they scale by up to just under 4x.
 */
`timescale 1ns/1ps
module acr_result_calc (
	input  wire logic [23:0] raw_i,
	input  wire logic [23:0] self_off_i,
	input  wire logic [23:0] self_gain_i,
	input  wire logic [23:0] sys_off_i,
	input  wire logic [23:0] sys_gain_i,
	input  wire logic [7:0]  setup_i,
	input  wire logic [7:0]  gcal_i,
	input  wire logic        pga_i,
	output logic      [23:0] res_o
);
	typedef logic signed [51:0] acr_wide_t;

	function automatic acr_wide_t sx(input logic [23:0] v);
		sx = {{28{v[23]}}, v};
	endfunction : sx

	acr_wide_t v;
	logic [2:0] sh;

	always_comb begin
		v = sx(raw_i);
		if (!gcal_i[acr_pkg::F_SELFO])
			v = v - sx(self_off_i);                      // R18
		if (!gcal_i[acr_pkg::F_SELFG])
			v = (v * $signed({28'h0, self_gain_i}))
				>>> acr_pkg::COEF_SHIFT;                 // R17
		// system offset after self terms, before system gain
		if (!gcal_i[acr_pkg::F_SYSO])
			v = v - sx(sys_off_i);                       // R16 R25
		if (!gcal_i[acr_pkg::F_SYSG])
			v = (v * $signed({28'h0, sys_gain_i}))
				>>> acr_pkg::COEF_SHIFT;                 // R15
		// gain codes above the table act as unity
		sh = gcal_i[7:acr_pkg::F_GAIN_LO];
		if (!pga_i || sh > acr_pkg::GAIN_MAX)
			sh = 3'h0;                                   // R24
		v = v <<< sh;                                    // R13 R14
		if (setup_i[acr_pkg::F_UNIPOL]) begin            // R2
			v = v <<< 1;
			if (v < 0)
				v = '0;                                      // R23
			else if (v > acr_pkg::UNI_MAX)
				v = acr_pkg::UNI_MAX;                        // R21
			res_o = v[23:0];                                 // R6
		end else begin
			if (v > acr_pkg::BIP_MAX)
				v = acr_pkg::BIP_MAX;                        // R23 R22
			else if (v < acr_pkg::BIP_MIN)
				v = acr_pkg::BIP_MIN;
			res_o = v[23:0];
			if (setup_i[acr_pkg::F_CODING])
				res_o[23] = ~v[23];                          // R6
		end
	end
endmodule : acr_result_calc

// ==== core/acr_top.sv ====
/*
 * acr_top: control registers, result register, pin port and
 * result shift-out of a delta-sigma converter.
 * assumes: classic wishbone master on clk_i; modulator/filter
 * delivers raw samples on clk_i; link pins are asynchronous.
 */
// Contract
// R1 - mains select 1 centres rates for 50Hz, 0 for 60Hz
// R2 - polarity bit 1 selects unipolar range, 0 bipolar
// R3 - clock source bit 1 external clock, 0 internal oscillator
// R4 - reference buffer enable 1 powers buffers, 0 bypasses them
// R5 - input buffer enable 1 powers buffers, 0 bypasses them
// R6 - bipolar coding bit 0 two's complement, 1 offset binary
// R7 - single shot converts once without latency then sleeps
// R8 - continuous mode discards the first three results
// R9 - with chip select low, end of conversion raises ready pin
// R10 - host syncs result reads to the ready pin rising edge
// R11 - direction 0 makes pin input; value bit reads pin level
// R12 - direction 1 drives the pin to its value bit
// R13 - gain field 0..4 gives gains 1,2,4,8,16
// R14 - digital gain follows all calibration corrections
// R15 - system gain bypass 1 skips system gain coefficient
// R16 - system offset bypass 1 skips system offset coefficient
// R17 - self gain bypass 1 skips self gain coefficient
// R18 - self offset bypass 1 skips self offset coefficient
// R19 - writes to the result register are ignored
// R20 - result shifts out bit 23 first, bit 0 last
// R21 - straight binary spans 0x000000 to 0xffffff
// R22 - two's complement spans 0x800000 to 0x7fffff
// R23 - inputs beyond range clip to minimum or maximum code
// R24 - without programmable gain the gain field does nothing
// R25 - system offset goes after self terms, before system gain
// R26 - unused and reserved control bits read zero
`timescale 1ns/1ps
module acr_top #(
	parameter bit HAS_PGA = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [23:0] raw_data_i,
	input  wire logic        raw_valid_i,
	input  wire logic [23:0] self_off_i,
	input  wire logic [23:0] self_gain_i,
	input  wire logic [23:0] sys_off_i,
	input  wire logic [23:0] sys_gain_i,
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	output logic             rdy_dout_o,
	input  wire logic [3:0]  gpio_i,
	output logic      [3:0]  gpio_o,
	output logic      [3:0]  gpio_oe_n_o,
	output logic             mains_50hz_o,
	output logic             unipolar_o,
	output logic             clk_ext_o,
	output logic             ref_buf_en_o,
	output logic             in_buf_en_o,
	output logic             conv_run_o,
	output logic             power_down_o
);
	// ----------------------------------------------------------
	// decode
	// ----------------------------------------------------------
	function automatic logic hit(input logic [4:0] a,
		input logic [2:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction : hit

	logic [7:0]  setup_r;
	logic [7:0]  pins_r;
	logic [7:0]  gcal_r;
	logic [23:0] result_r;
	logic [23:0] calc_res;
	logic [5:0]  sync_q;
	logic [3:0]  gpio_s;
	logic        sclk_s;
	logic        cs_n_s;
	logic        sclk_prev_r;
	logic        sclk_fall;
	logic        wb_req;
	logic        wr_lane0;
	logic        wr_setup;
	logic        res_ld;
	logic [1:0]  skip_r;
	logic [23:0] shift_r;
	logic [4:0]  bits_r;
	acr_pkg::acr_state_t state_r;

	assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_lane0 = wb_req & wb_we_i & wb_sel_i[0];
	assign wr_setup = wr_lane0 & hit(wb_adr_i, acr_pkg::IDX_SETUP);

	// ----------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------
	acr_sync #(
		.W (6)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   ({cs_n_i, sclk_i, gpio_i}),
		.q_o   (sync_q)
	);

	assign gpio_s    = sync_q[3:0];
	assign sclk_s    = sync_q[4];
	assign cs_n_s    = sync_q[5];
	assign sclk_fall = sclk_prev_r & ~sclk_s;

	// ----------------------------------------------------------
	// result arithmetic
	// ----------------------------------------------------------
	acr_result_calc u_calc (
		.raw_i       (raw_data_i),
		.self_off_i  (self_off_i),
		.self_gain_i (self_gain_i),
		.sys_off_i   (sys_off_i),
		.sys_gain_i  (sys_gain_i),
		.setup_i     (setup_r),
		.gcal_i      (gcal_r),
		.pga_i       (HAS_PGA),
		.res_o       (calc_res)
	);

	// ----------------------------------------------------------
	// control registers
	// ----------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			setup_r <= acr_pkg::SETUP_RST;
			pins_r  <= acr_pkg::PINS_RST;
			gcal_r  <= acr_pkg::GCAL_RST;
		end else if (ce_i && wr_lane0) begin
			if (hit(wb_adr_i, acr_pkg::IDX_SETUP))
				setup_r <= wb_dat_i[7:0] & acr_pkg::SETUP_MASK; // R26
			if (hit(wb_adr_i, acr_pkg::IDX_PINS))
				pins_r <= wb_dat_i[7:0];
			if (hit(wb_adr_i, acr_pkg::IDX_GAINCAL))
				gcal_r <= wb_dat_i[7:0] & acr_pkg::GCAL_MASK;   // R26
		end
	end

	// ----------------------------------------------------------
	// analog front-end controls
	// ----------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mains_50hz_o <= 1'b0;
			unipolar_o   <= 1'b0;
			clk_ext_o    <= 1'b0;
			ref_buf_en_o <= 1'b0;
			in_buf_en_o  <= 1'b0;
		end else if (ce_i && wr_setup) begin
			mains_50hz_o <= wb_dat_i[acr_pkg::F_MAINS];  // R1
			unipolar_o   <= wb_dat_i[acr_pkg::F_UNIPOL]; // R2
			clk_ext_o    <= wb_dat_i[acr_pkg::F_CLKSRC]; // R3
			ref_buf_en_o <= wb_dat_i[acr_pkg::F_REFERENCE_BUFFER_ENABLE]; // R4
			in_buf_en_o  <= wb_dat_i[acr_pkg::F_INBUF];  // R5
		end
	end

	// ----------------------------------------------------------
	// general-purpose pins
	// ----------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gpio_o      <= 4'hf;
			gpio_oe_n_o <= 4'hf;
		end else if (ce_i) begin
			gpio_o      <= pins_r[3:0];                  // R12
			gpio_oe_n_o <= ~pins_r[7:acr_pkg::F_DIR_LO]; // R12
		end
	end

	// ----------------------------------------------------------
	// conversion sequencing
	// ----------------------------------------------------------
	// a setup write restarts conversion in the chosen mode;
	// after reset the block sleeps until software commands it
	assign res_ld = (state_r == acr_pkg::ST_CONV) && raw_valid_i
		&& (skip_r == 2'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r      <= acr_pkg::ST_SLEEP;
			skip_r       <= 2'h0;
			conv_run_o   <= 1'b0;
			power_down_o <= 1'b1;
		end else if (ce_i) begin
			case (state_r)
				acr_pkg::ST_SLEEP: begin
					if (wr_setup) begin
						state_r      <= acr_pkg::ST_CONV;
						conv_run_o   <= 1'b1;
						power_down_o <= 1'b0;
						skip_r <= wb_dat_i[acr_pkg::F_SINGLE] ?
							2'h0 : acr_pkg::SKIP_CNT;        // R7 R8
					end
				end
				acr_pkg::ST_CONV: begin
					if (wr_setup) begin
						skip_r <= wb_dat_i[acr_pkg::F_SINGLE] ?
							2'h0 : acr_pkg::SKIP_CNT;        // R8
					end else if (raw_valid_i && skip_r != 2'h0) begin
						skip_r <= skip_r - 2'h1;             // R8
					end else if (res_ld &&
						setup_r[acr_pkg::F_SINGLE]) begin
						state_r      <= acr_pkg::ST_SLEEP;   // R7
						conv_run_o   <= 1'b0;
						power_down_o <= 1'b1;
					end
				end
				default: begin
					state_r      <= acr_pkg::ST_SLEEP;
					conv_run_o   <= 1'b0;
					power_down_o <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------
	// result register
	// ----------------------------------------------------------
	// only a finished conversion loads it; bus writes never do
	always_ff @(posedge clk_i) begin
		if (rst_i)
			result_r <= 24'h000000;
		else if (ce_i && res_ld && !wr_setup)
			result_r <= calc_res;                          // R19
	end

	// ----------------------------------------------------------
	// ready / data-out shifter
	// ----------------------------------------------------------
	// a read not started from the ready edge may see the next
	// result mid-shift; the host must sync to the rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_prev_r <= 1'b0;
			shift_r     <= 24'h000000;
			bits_r      <= 5'h00;
			rdy_dout_o  <= 1'b0;
		end else if (ce_i) begin
			sclk_prev_r <= sclk_s;
			if (cs_n_s) begin
				bits_r     <= 5'h00;
				rdy_dout_o <= 1'b0;
			end else if (res_ld && !wr_setup) begin
				shift_r    <= calc_res;                  // R10
				bits_r     <= acr_pkg::RES_BITS;
				rdy_dout_o <= 1'b1;                      // R9
			end else if (sclk_fall) begin
				if (bits_r != 5'h00) begin
					rdy_dout_o <= shift_r[23];           // R20
					shift_r    <= {shift_r[22:0], 1'b0};
					bits_r     <= bits_r - 5'h01;
				end else begin
					rdy_dout_o <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------
	// one wait state; unmapped addresses ack with zero data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			if (wb_req && !wb_we_i) begin
				if (hit(wb_adr_i, acr_pkg::IDX_SETUP))
					wb_dat_o[7:0] <= setup_r;                // R26
				if (hit(wb_adr_i, acr_pkg::IDX_PINS))
					wb_dat_o[7:0] <= {pins_r[7:4],
						(pins_r[7:4] & pins_r[3:0]) |
						(~pins_r[7:4] & gpio_s)};            // R11
				if (hit(wb_adr_i, acr_pkg::IDX_GAINCAL))
					wb_dat_o[7:0] <= gcal_r;                 // R26
				if (hit(wb_adr_i, acr_pkg::IDX_RESULT))
					wb_dat_o[23:0] <= result_r;
			end
		end
	end

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_MAINS_FOLLOWS_WRITE: assert property ( // R1
		ce_i && wr_setup |=> mains_50hz_o == $past(wb_dat_i[7])
		&& clk_ext_o == $past(wb_dat_i[5]))
		else $error("front-end controls did not follow write");

	AST_RESULT_WRITE_IGNORED: assert property ( // R19
		ce_i && wr_lane0 && hit(wb_adr_i, acr_pkg::IDX_RESULT)
		&& !res_ld |=> $stable(result_r))
		else $error("result register changed on a bus write");

	AST_PIN_DRIVE: assert property ( // R12
		ce_i && wr_lane0 && hit(wb_adr_i, acr_pkg::IDX_PINS)
		&& wb_dat_i[4] ##1 ce_i |=> !gpio_oe_n_o[0]
		&& gpio_o[0] == $past(wb_dat_i[0], 2))
		else $error("output pin not driven from value bit");

	AST_PIN_READBACK: assert property ( // R11
		wb_req && !wb_we_i && ce_i && !pins_r[4]
		&& hit(wb_adr_i, acr_pkg::IDX_PINS)
		|=> wb_ack_o && wb_dat_o[0] == $past(gpio_s[0]))
		else $error("input pin level not read back");

	AST_SINGLE_SLEEPS: assert property ( // R7
		ce_i && res_ld && setup_r[1] && !wr_setup
		|=> power_down_o && !conv_run_o)
		else $error("single shot did not power down");

	AST_SKIP_LOADED: assert property ( // R8
		ce_i && wr_setup && !wb_dat_i[1]
		|=> skip_r == 2'h3 && !res_ld)
		else $error("continuous start did not skip three");

	AST_READY_RISES: assert property ( // R9
		ce_i && res_ld && !cs_n_s && !wr_setup
		|=> rdy_dout_o && bits_r == 5'h18)
		else $error("ready pin did not rise on end of conversion");

	AST_MSB_FIRST: assert property ( // R20
		ce_i && !cs_n_s && sclk_fall && !res_ld && bits_r != 5'h00
		|=> rdy_dout_o == $past(shift_r[23]))
		else $error("shift order is not msb first");

	AST_RESERVED_ZERO: assert property ( // R26
		wb_ack_o |-> wb_dat_o[31:24] == 8'h00
		&& !(setup_r[0] || gcal_r[0]))
		else $error("reserved bit reads nonzero");
endmodule : acr_top

// ==== tb/acr_host_model.sv ====
/*
 * acr_host_model: host end of the serial link; reads one
 * 24-bit result per frame, sampling on the rising link edge.
 * assumes: the bench calls read_frame after the ready rise.
 */
`timescale 1ns/1ps
module acr_host_model (
	input  wire logic rdy_dout_i,
	output logic      cs_n_o,
	output logic      sclk_o
);
	// ------------------------------------------------------
	// frame reader
	// ------------------------------------------------------
	// select stays low so that every end of conversion is seen
	initial begin
		cs_n_o = 1'b0;
		sclk_o = 1'b1;
	end

	// the extra falling edge parks the line at 0, so the next
	// result always shows a clean 0 to 1 edge
	task automatic read_frame(output logic [23:0] v);
		for (int i = 23; i >= -1; i--) begin
			sclk_o = 1'b0;
			#32;
			sclk_o = 1'b1;
			if (i >= 0)
				v[i] = rdy_dout_i;
			#32;
		end
	endtask : read_frame
endmodule : acr_host_model

// ==== tb/test_acr_top.sv ====
/*
 * test_acr_top: self-checking bench of acr_top with the host
 * model on the link. assumes: core files compiled first.
 */
`timescale 1ns/1ps
module test_acr_top;
	// ------------------------------------------------------
	// signals and case table
	// ------------------------------------------------------
	typedef struct packed {
		logic [7:0]  setup;
		logic [7:0]  gcal;
		logic [23:0] raw;
		logic [23:0] exp;
	} acr_row_t;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce    = 1'b1;
	logic [3:0]  gpi   = 4'h9;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [4:0]  adr   = 5'h00;
	logic [31:0] wdat  = 32'h0;
	logic [23:0] raw   = 24'h0;
	logic        rvld  = 1'b0;
	logic [31:0] rdat;
	logic        ack;
	logic        cs_n;
	logic        sclk;
	logic        rdy;
	logic [3:0]  gpo;
	logic [3:0]  oe_n;
	logic [4:0]  fe;
	logic        run;
	logic        pdn;
	int          bad_count = 0;
	int          checks = 0;

	// self gain 1.5x and system gain 2x expose the order
	acr_row_t rows [19] = '{
		'{8'h02, 8'h1e, 24'h000123, 24'h000123},
		'{8'h06, 8'h1e, 24'h000123, 24'h800123},
		'{8'h42, 8'h1e, 24'h000123, 24'h000246},
		'{8'h42, 8'h1e, 24'h400000, 24'h800000},
		'{8'h42, 8'h1e, 24'hffff00, 24'h000000},
		'{8'h46, 8'h3e, 24'h7fffff, 24'hffffff},
		'{8'h02, 8'h3e, 24'h7fffff, 24'h7fffff},
		'{8'h02, 8'h1e, 24'h800000, 24'h800000},
		'{8'h02, 8'h1e, 24'h000001, 24'h000001},
		'{8'h02, 8'h3e, 24'h000001, 24'h000002},
		'{8'h02, 8'h5e, 24'h000001, 24'h000004},
		'{8'h02, 8'h7e, 24'h000001, 24'h000008},
		'{8'h02, 8'h9e, 24'h000001, 24'h000010},
		'{8'h02, 8'h00, 24'h000100, 24'h000290},
		'{8'h02, 8'h02, 24'h000100, 24'h0002c0},
		'{8'h02, 8'h04, 24'h000100, 24'h0001a0},
		'{8'h02, 8'h08, 24'h000100, 24'h0002d0},
		'{8'h02, 8'h10, 24'h000100, 24'h000148},
		'{8'h02, 8'h20, 24'h000100, 24'h000520}
	};
	logic [4:0]  rst_adr [5] = '{5'h04, 5'h08, 5'h0c, 5'h10, 5'h00};
	logic [31:0] rst_exp [5] = '{32'h02, 32'h06, 32'h1e, 32'h0, 32'h0};

	acr_top i_acr_top (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack),
		.raw_data_i(raw), .raw_valid_i(rvld),
		.self_off_i(24'h000010), .self_gain_i(24'h600000),
		.sys_off_i(24'h000020), .sys_gain_i(24'h800000),
		.cs_n_i(cs_n), .sclk_i(sclk), .rdy_dout_o(rdy),
		.gpio_i(gpi), .gpio_o(gpo), .gpio_oe_n_o(oe_n),
		.mains_50hz_o(fe[4]), .unipolar_o(fe[3]),
		.clk_ext_o(fe[2]), .ref_buf_en_o(fe[1]),
		.in_buf_en_o(fe[0]), .conv_run_o(run),
		.power_down_o(pdn)
	);

	acr_host_model i_acr_host_model (
		.rdy_dout_i(rdy), .cs_n_o(cs_n), .sclk_o(sclk)
	);

	// ------------------------------------------------------
	// tasks
	// ------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// holds the request until the rising edge that samples ack
	// high, takes read data there and releases at that edge
	task automatic wb(input logic w, input logic [4:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= wd;
		do @(posedge clk_i); while (ack !== 1'b1 && n++ < 20);
		rd = rdat;
		chk({31'h0, ack}, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic pulse(input logic [23:0] x);
		@(posedge clk_i);
		raw <= x;
		rvld <= 1'b1;
		@(posedge clk_i);
		rvld <= 1'b0;
	endtask : pulse

	task automatic give_verdict;
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------
	// clock, watchdog and sequence
	// ------------------------------------------------------
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		give_verdict();
	end

	initial begin
		logic [31:0] d;
		logic [23:0] v;
		int          n;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(1'b1, 5'h0c, {24'h0, rows[i].gcal}, d);
			wb(1'b1, 5'h04, {24'h0, rows[i].setup}, d);
			chk({27'h0, fe}, {27'h0, rows[i].setup[7:3]});
			pulse(rows[i].raw);
			n = 0;
			while (rdy !== 1'b1 && n++ < 20) @(negedge clk_i);
			chk({31'h0, rdy}, 32'h1);
			i_acr_host_model.read_frame(v);
			chk({8'h0, v}, {8'h0, rows[i].exp});
			wb(1'b0, 5'h10, 32'h0, d);
			chk(d, {8'h0, rows[i].exp});
			chk({30'h0, run, pdn}, 32'h1);
		end
		wb(1'b1, 5'h10, 32'hffffff, d);
		pulse(24'h000777);
		wb(1'b0, 5'h10, 32'h0, d);
		chk(d, 32'h520);
		wb(1'b1, 5'h04, 32'h00, d);
		for (int k = 1; k <= 4; k++) begin
			pulse(k[23:0]);
			wb(1'b0, 5'h10, 32'h0, d);
			chk(d, (k < 4) ? 32'h520 : 32'hffff38);
		end
		chk({31'h0, run}, 32'h1);
		// a sample offered while the clock enable is low is lost
		ce <= 1'b0;
		pulse(24'h000010);
		ce <= 1'b1;
		wb(1'b0, 5'h10, 32'h0, d);
		chk(d, 32'hffff38);
		wb(1'b1, 5'h08, 32'hb6, d);
		@(negedge clk_i);
		chk({26'h0, oe_n, gpo[3], gpo[1]}, 32'h11);
		wb(1'b0, 5'h08, 32'h0, d);
		chk(d, 32'hb2);
		gpi <= 4'h6;
		wb(1'b1, 5'h04, 32'hff, d);
		chk({27'h0, fe}, 32'h1f);
		wb(1'b0, 5'h04, 32'h0, d);
		chk(d, 32'hfe);
		wb(1'b0, 5'h08, 32'h0, d);
		chk(d, 32'hb6);
		wb(1'b1, 5'h0c, 32'hff, d);
		wb(1'b0, 5'h0c, 32'h0, d);
		chk(d, 32'hfe);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({26'h0, oe_n, run, pdn}, 32'h3d);
		foreach (rst_adr[k]) begin
			wb(1'b0, rst_adr[k], 32'h0, d);
			chk(d, rst_exp[k]);
		end
		give_verdict();
	end
endmodule : test_acr_top
